// >>> common/sdpc_pkg.sv
// Package: constants for the SDRAM refresh and power-mode controller
package sdpc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS   = 8000;                 // 125 MHz
  localparam int TRP_PS          = 18000;                // Precharge to refresh, min
  localparam int TRFC_PS         = 72000;                // Refresh cycle, min
  localparam int TRAS_PS         = 42000;                // Least self refresh stay
  localparam int TXSR_CLK        = 2;                    // NOP clocks after self refresh exit
  localparam int TREF_US         = 64000;                // Refresh period, 64 ms
  localparam int ROW_COUNT       = 8192;                 // Rows per refresh period
  localparam int TRP_CYC         = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRFC_CYC        = (TRFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRAS_CYC        = (TRAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest spacing of distributed refresh rounds down
  localparam int TREFI_CYC       = (TREF_US / ROW_COUNT) * 1000 * 1000 / CLK_PERIOD_PS;
  // Power-down must end inside the refresh interval too
  localparam int PD_LIMIT_CYC    = TREFI_CYC;
  localparam int CNT_W           = 16;

  // ----------------------------------------
  // Command encoding {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_INHIBIT = 4'hF;
  localparam logic [3:0] CMD_PRE     = 4'h2;
  localparam logic [3:0] CMD_REF     = 4'h1;
  localparam logic [3:0] CMD_DPD     = 4'h6;
  localparam int         A_ALLBANK   = 10;               // Address bit that selects all banks

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_PRE     = 4'h1,
    ST_TRP     = 4'h2,
    ST_REF     = 4'h3,
    ST_TRFC    = 4'h4,
    ST_SR      = 4'h5,
    ST_SR_EXIT = 4'h6,
    ST_PD      = 4'h7,
    ST_PD_EXIT = 4'h8,
    ST_DPD     = 4'h9,
    ST_SUSP    = 4'hA
  } sdpc_state_t;

endpackage : sdpc_pkg

// >>> logic/sdpc_wait_cnt.sv
// Down counter that times the spacing between commands
`timescale 1ns/1ps
`default_nettype none
module sdpc_wait_cnt (
  // Clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          rst_in,
  // Load and status
  input  wire logic                          load_in,
  input  wire logic [sdpc_pkg::CNT_W-1:0]    value_in,
  output logic                               done_out
);
  logic [sdpc_pkg::CNT_W-1:0] cnt_reg;

  // Load wins over counting, stops at zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else if (load_in) begin
      cnt_reg <= value_in;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Done once no wait remains and nothing is being loaded
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      done_out <= 1'b1;
    end else begin
      done_out <= !load_in && (cnt_reg <= 1);
    end
  end
endmodule // sdpc_wait_cnt
`default_nettype wire

// >>> logic/sdpc_ctrl.sv
// SDRAM refresh and power-mode controller (host side of the command bus)
//
// How it works
// R1 - Device ends interrupted auto-precharge write itself
// R2 - Device keeps data before interrupting write
// R3 - One AUTO REFRESH command per refresh
// R4 - Precharge all, wait tRP, then refresh
// R5 - Device ignores address during refresh
// R6 - Only NOP on bus during tRFC
// R7 - Refresh spaced at tREF over row count
// R8 - Burst refresh alternative, tRFC apart
// R9 - Self refresh: refresh encoding, CKE held low
// R10 - Stay in self refresh at least tRAS
// R11 - Exit: clock stable, CKE high, NOPs
// R12 - Resume distributed refresh after self refresh
// R13 - Power-down: CKE low with NOP
// R14 - Leave power-down within refresh interval
// R15 - Exit power-down with NOP, CKE high
// R16 - Deep power-down: DPD encoding, CKE low
// R17 - Leave deep power-down, then full initialization
// R18 - Clock suspend: CKE low during burst
// R19 - Device freezes burst while suspended
// R20 - Device resumes after CKE high
// R21 - Refresh encoding CS RAS CAS low
`timescale 1ns/1ps
`default_nettype none
module sdpc_ctrl (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // User requests (same clock domain)
  input  wire logic        burst_refresh_in,    // Level: use burst refresh instead of spaced
  input  wire logic        self_refresh_in,     // Level: hold device in self refresh
  input  wire logic        power_down_in,       // Level: hold device in power-down
  input  wire logic        deep_pd_in,          // Level: hold device in deep power-down
  input  wire logic        suspend_in,          // Level: suspend clock during user burst
  input  wire logic        burst_active_in,     // A column burst is running
  // User status
  output logic             busy_out,
  output logic             need_init_out,       // Set after deep power-down exit
  output logic             refresh_pulse_out,
  // SDRAM command pins
  output logic             cke_out,
  output logic             cs_n_out,
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic [12:0]      addr_out
);
  sdpc_pkg::sdpc_state_t state_reg;
  sdpc_pkg::sdpc_state_t state_next;
  logic [sdpc_pkg::CNT_W-1:0] wait_val;
  logic                       wait_load;
  logic                       wait_done;
  logic [sdpc_pkg::CNT_W-1:0] refi_reg;
  logic                       ref_due_reg;
  logic [sdpc_pkg::CNT_W-1:0] burst_left_reg;
  logic [sdpc_pkg::CNT_W-1:0] pd_cnt_reg;

  // ----------------------------------------
  // Spacing timer
  // ----------------------------------------
  sdpc_wait_cnt u_wait (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (wait_load),
    .value_in   (wait_val),
    .done_out   (wait_done)
  );

  // ----------------------------------------
  // Refresh scheduling
  // ----------------------------------------
  // Interval counter keeps running in every mode so that spacing resumes at once
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      refi_reg <= '0;
    end else if (refi_reg == sdpc_pkg::CNT_W'(sdpc_pkg::TREFI_CYC - 1)) begin
      refi_reg <= '0;
    end else begin
      refi_reg <= refi_reg + 1'b1;
    end
  end

  // Due flag: a tick sets it, issuing the last refresh of a burst group (or the single spaced one) clears it; set wins
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ref_due_reg <= 1'b0;
    end else if (refi_reg == sdpc_pkg::CNT_W'(sdpc_pkg::TREFI_CYC - 1)) begin
      ref_due_reg <= 1'b1;                                              // R7 R12
    end else if (state_reg == sdpc_pkg::ST_REF && burst_left_reg <= 1) begin
      ref_due_reg <= 1'b0;
    end
  end

  // Burst mode issues a group of refreshes per tick; trade: bus held longer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      burst_left_reg <= '0;
    end else if (state_reg == sdpc_pkg::ST_IDLE && ref_due_reg && burst_refresh_in) begin
      burst_left_reg <= sdpc_pkg::CNT_W'(8);                            // R8
    end else if (state_reg == sdpc_pkg::ST_REF && burst_left_reg != '0) begin
      burst_left_reg <= burst_left_reg - 1'b1;
    end
  end

  // Power-down dwell is capped so no refresh is missed
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || state_reg != sdpc_pkg::ST_PD) begin
      pd_cnt_reg <= '0;
    end else begin
      pd_cnt_reg <= pd_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    wait_load  = 1'b0;
    wait_val   = '0;
    case (state_reg)
      sdpc_pkg::ST_IDLE: begin
        if (deep_pd_in || ref_due_reg || self_refresh_in) begin
          state_next = sdpc_pkg::ST_PRE;                                // R4
        end else if (suspend_in && burst_active_in) begin
          state_next = sdpc_pkg::ST_SUSP;                               // R18
        end else if (power_down_in && !burst_active_in) begin
          state_next = sdpc_pkg::ST_PD;                                 // R13
        end
      end
      sdpc_pkg::ST_PRE: begin
        state_next = sdpc_pkg::ST_TRP;
        wait_load  = 1'b1;
        wait_val   = sdpc_pkg::CNT_W'(sdpc_pkg::TRP_CYC - 1);          // R4
      end
      sdpc_pkg::ST_TRP: begin
        if (wait_done) begin
          if (deep_pd_in) begin
            state_next = sdpc_pkg::ST_DPD;                              // R16
          end else if (self_refresh_in && !ref_due_reg) begin
            state_next = sdpc_pkg::ST_SR;                               // R9
            wait_load  = 1'b1;
            wait_val   = sdpc_pkg::CNT_W'(sdpc_pkg::TRAS_CYC);         // R10
          end else begin
            state_next = sdpc_pkg::ST_REF;
          end
        end
      end
      sdpc_pkg::ST_REF: begin
        state_next = sdpc_pkg::ST_TRFC;
        wait_load  = 1'b1;
        wait_val   = sdpc_pkg::CNT_W'(sdpc_pkg::TRFC_CYC - 1);         // R6
      end
      sdpc_pkg::ST_TRFC: begin
        if (wait_done) begin
          state_next = (burst_left_reg != '0) ? sdpc_pkg::ST_REF : sdpc_pkg::ST_IDLE; // R8
        end
      end
      sdpc_pkg::ST_SR: begin
        if (wait_done && !self_refresh_in) begin
          state_next = sdpc_pkg::ST_SR_EXIT;                            // R10 R11
          wait_load  = 1'b1;
          wait_val   = sdpc_pkg::CNT_W'(sdpc_pkg::TXSR_CLK);
        end
      end
      sdpc_pkg::ST_SR_EXIT: begin
        if (wait_done) begin
          state_next = sdpc_pkg::ST_IDLE;                               // R12
        end
      end
      sdpc_pkg::ST_PD: begin
        if (!power_down_in || ref_due_reg ||
            pd_cnt_reg >= sdpc_pkg::CNT_W'(sdpc_pkg::PD_LIMIT_CYC - 1)) begin
          state_next = sdpc_pkg::ST_PD_EXIT;                            // R14
        end
      end
      sdpc_pkg::ST_PD_EXIT: begin
        state_next = sdpc_pkg::ST_IDLE;                                 // R15
      end
      sdpc_pkg::ST_DPD: begin
        if (!deep_pd_in) begin
          state_next = sdpc_pkg::ST_IDLE;                               // R17
        end
      end
      sdpc_pkg::ST_SUSP: begin
        if (!suspend_in || !burst_active_in) begin
          state_next = sdpc_pkg::ST_IDLE;                               // R20
        end
      end
      default: begin
        state_next = sdpc_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= sdpc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Pin drivers, registered from next state
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= sdpc_pkg::CMD_INHIBIT;
      cke_out  <= 1'b1;
      addr_out <= '0;
    end else begin
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= sdpc_pkg::CMD_NOP; // R6 R11 R15
      cke_out  <= 1'b1;
      addr_out <= '0;
      case (state_next)
        sdpc_pkg::ST_PRE: begin
          {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= sdpc_pkg::CMD_PRE;
          addr_out[sdpc_pkg::A_ALLBANK] <= 1'b1;                        // R4
        end
        sdpc_pkg::ST_REF: begin
          {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= sdpc_pkg::CMD_REF; // R3 R21
        end
        sdpc_pkg::ST_SR: begin
          cke_out <= 1'b0;                                              // R9
          if (state_reg != sdpc_pkg::ST_SR) begin
            {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= sdpc_pkg::CMD_REF; // R21
          end
        end
        sdpc_pkg::ST_PD, sdpc_pkg::ST_SUSP: begin
          cke_out <= 1'b0;                                              // R13 R18
        end
        sdpc_pkg::ST_DPD: begin
          cke_out <= 1'b0;                                              // R16
          if (state_reg != sdpc_pkg::ST_DPD) begin
            {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= sdpc_pkg::CMD_DPD;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      busy_out          <= 1'b0;
      refresh_pulse_out <= 1'b0;
    end else begin
      busy_out          <= (state_next != sdpc_pkg::ST_IDLE);
      refresh_pulse_out <= (state_next == sdpc_pkg::ST_REF);
    end
  end

  // Array contents lost: user must rerun initialization; cleared by reset only
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      need_init_out <= 1'b0;
    end else if (state_reg == sdpc_pkg::ST_DPD && state_next == sdpc_pkg::ST_IDLE) begin
      need_init_out <= 1'b1;                                            // R17
    end
  end
endmodule // sdpc_ctrl
`default_nettype wire

// >>> testbench/sdpc_ctrl_properties.sv
// Checker: command timing of the refresh and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module sdpc_ctrl_check (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // User side
  input wire logic suspend_in,
  input wire logic burst_active_in,
  input wire logic refresh_pulse_out,
  // Command pins
  input wire logic cke_out,
  input wire logic cs_n_out,
  input wire logic ras_n_out,
  input wire logic cas_n_out,
  input wire logic we_n_out
);
  wire logic [3:0] cmd = {cs_n_out, ras_n_out, cas_n_out, we_n_out};
  wire logic       nop = (cmd == sdpc_pkg::CMD_NOP) || (cmd == sdpc_pkg::CMD_INHIBIT);
  logic            sr_reg;
  logic            dpd_reg;
  int              lo_reg;
  int              gap_reg;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Low-CKE owner and counters; deep power-down stays marked since refresh stops until reinit
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sr_reg <= 1'b0;
      dpd_reg <= 1'b0;
      lo_reg <= 0;
      gap_reg <= 0;
    end else begin
      sr_reg <= !cke_out && (sr_reg || cmd == sdpc_pkg::CMD_REF);
      dpd_reg <= dpd_reg || (!cke_out && cmd == sdpc_pkg::CMD_DPD);
      lo_reg <= (!cke_out && !sr_reg && !dpd_reg) ? lo_reg + 1 : 0;
      gap_reg <= (refresh_pulse_out || sr_reg || dpd_reg) ? 0 : gap_reg + 1;
    end
  end
  sequence s_nop;
    nop;
  endsequence
  sequence s_ref;
    cke_out && cmd == sdpc_pkg::CMD_REF;
  endsequence
  AST_REF_PRE_GAP: assert property (s_ref |-> $past(nop, 1) && $past(nop, 2))
    else $error("refresh too soon after a command");
  AST_TRFC_NOP: assert property (s_ref |=> s_nop [*8])
    else $error("command inside refresh cycle");
  AST_REF_PULSE: assert property (refresh_pulse_out == (cke_out && cmd == sdpc_pkg::CMD_REF))
    else $error("refresh pulse and pins disagree");
  AST_SR_HOLD: assert property ((cmd == sdpc_pkg::CMD_REF && !cke_out && $past(cke_out)) |=> !cke_out [*5])
    else $error("self refresh left early");
  // Two NOP clocks only after self refresh; suspend and deep power-down exits may be followed by a command at once
  AST_EXIT_NOP: assert property (($rose(cke_out) && sr_reg) |-> s_nop [*2])
    else $error("fewer than two NOPs after self refresh exit");
  AST_PD_EXIT_NOP: assert property ($rose(cke_out) |-> s_nop)
    else $error("no NOP at CKE rise");
  // A NOP with CKE falling while a burst runs is only legal as a clock suspend
  AST_SUSP_ENTRY: assert property (($fell(cke_out) && nop && $past(burst_active_in)) |-> $past(suspend_in))
    else $error("CKE dropped during a burst without suspend");
  AST_LOW_ENTRY: assert property ($fell(cke_out) |-> nop || cmd == sdpc_pkg::CMD_REF || cmd == sdpc_pkg::CMD_DPD)
    else $error("bad command at CKE fall");
  AST_PD_LIMIT: assert property (lo_reg <= sdpc_pkg::PD_LIMIT_CYC)
    else $error("power-down too long");
  AST_REF_SPACING: assert property (gap_reg <= sdpc_pkg::TREFI_CYC + 32)
    else $error("refresh interval exceeded");
endmodule // sdpc_ctrl_check
bind sdpc_ctrl sdpc_ctrl_check sdpc_ctrl_check_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .suspend_in(suspend_in),
  .burst_active_in(burst_active_in), .refresh_pulse_out(refresh_pulse_out), .cke_out(cke_out), .cs_n_out(cs_n_out),
  .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .we_n_out(we_n_out));
`default_nettype wire

// >>> testbench/sdpc_sdram_model.sv
// Behavioural SDRAM following refresh and power-mode commands
`timescale 1ns/1ps
`default_nettype none
module sdpc_sdram_model (
  // Clock and model reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Command pins
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [12:0] addr_in,
  // State: 0 normal, 1 power-down, 2 self refresh, 3 deep power-down
  output logic      [1:0]  mode_out,
  output int               refs_out,
  output int               edges_out      // Internal clock edges actually taken
);
  logic cke_q;
  wire logic [3:0] cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  wire logic       nop = (cmd == sdpc_pkg::CMD_NOP) || (cmd == sdpc_pkg::CMD_INHIBIT);
  // Mode follows CKE and the command registered with it; bursts are not modelled, no data pins here
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_out <= 2'h0;
      refs_out <= 0;
    end else begin
      case (mode_out)
        2'h0: begin
          if (!cke_in && cmd == sdpc_pkg::CMD_REF) mode_out <= 2'h2;
          else if (!cke_in && cmd == sdpc_pkg::CMD_DPD) mode_out <= 2'h3;
          else if (!cke_in && nop) mode_out <= 2'h1;
          else if (cmd == sdpc_pkg::CMD_REF) refs_out <= refs_out + 1;
        end
        // Only CKE is heard while low; no refresh counted in power-down
        default: if (cke_in) mode_out <= 2'h0;
      endcase
    end
  end

  // Internal clock: the edge after a low CKE sample is swallowed, so edges_out stays frozen
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cke_q     <= 1'b1;
      edges_out <= 0;
    end else begin
      cke_q <= cke_in;
      if (cke_q) begin
        edges_out <= edges_out + 1;
      end
    end
  end
endmodule // sdpc_sdram_model
`default_nettype wire

// >>> testbench/sdpc_ctrl_test.sv
// Testbench: refresh and power-mode controller against a behavioural SDRAM
`timescale 1ns/1ps
`default_nettype none
module sdpc_ctrl_test;
  localparam int TREFI = sdpc_pkg::TREFI_CYC + 40;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        burst_ref = 1'b0;
  logic        self_ref = 1'b0;
  logic        pwr_down = 1'b0;
  logic        deep_pd = 1'b0;
  logic        susp = 1'b0;
  logic        burst_act = 1'b0;
  logic        busy;
  logic        need_init;
  logic        ref_pulse;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [12:0] addr;
  logic [1:0]  mode;
  int          refs;
  int          edges;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;
  wire  [3:0]  cmd = {cs_n, ras_n, cas_n, we_n};
  wire         nop = (cmd === sdpc_pkg::CMD_NOP) || (cmd === sdpc_pkg::CMD_INHIBIT);
  sdpc_ctrl sdpc_ctrl_i (.clk_sys_in(clk_sys), .rst_in(rst), .burst_refresh_in(burst_ref), .self_refresh_in(self_ref),
    .power_down_in(pwr_down), .deep_pd_in(deep_pd), .suspend_in(susp), .burst_active_in(burst_act), .busy_out(busy),
    .need_init_out(need_init), .refresh_pulse_out(ref_pulse), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
    .cas_n_out(cas_n), .we_n_out(we_n), .addr_out(addr));
  sdpc_sdram_model sdpc_sdram_model_i (.clk_in(clk_sys), .rst_in(rst), .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n),
    .cas_n_in(cas_n), .we_n_in(we_n), .addr_in(addr), .mode_out(mode), .refs_out(refs), .edges_out(edges));
  // Clock, and a cycle ceiling well above the few thousand cycles the run needs
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  // Drives and samples both land 1 ns after the edge, clear of the design's updates
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic wait_cke(input logic lvl, input int lim, output int n);
    for (n = 0; cke !== lvl && n < lim; n++) tick();
  endtask
  task automatic wait_ref(input int lim, output int n);
    for (n = 0; ref_pulse !== 1'b1 && n < lim; n++) tick();
  endtask
  task automatic t_refresh;
    int n;
    int r0;
    wait_ref(TREFI, n);
    check(cmd, sdpc_pkg::CMD_REF);
    r0 = refs;
    tick();
    check(refs, r0 + 1);
  endtask
  task automatic t_self_ref;
    int n;
    self_ref = 1'b1;
    wait_cke(1'b0, 40, n);
    check(cmd, sdpc_pkg::CMD_REF);
    tick();
    check(mode, 2);
    self_ref = 1'b0;
    wait_cke(1'b1, 40, n);
    check(n + 1 >= sdpc_pkg::TRAS_CYC, 1);
    check(nop, 1);
    tick();
    check(nop, 1);
    check(mode, 0);
    wait_ref(TREFI, n);
    check(ref_pulse, 1);
  endtask
  task automatic t_power_down;
    int n;
    burst_act = 1'b1;
    pwr_down = 1'b1;
    tick(30);
    check(mode, 0);
    burst_act = 1'b0;
    wait_cke(1'b0, 40, n);
    check(nop, 1);
    tick();
    check(mode, 1);
    wait_cke(1'b1, sdpc_pkg::PD_LIMIT_CYC + 40, n);
    check(nop, 1);
    pwr_down = 1'b0;
    tick(20);
    check(cke, 1);
  endtask
  task automatic t_suspend;
    int n;
    int e0;
    burst_act = 1'b1;
    susp = 1'b1;
    wait_cke(1'b0, 20, n);
    check(cke, 0);
    tick();
    e0 = edges;
    tick(3);
    check(edges, e0);
    susp = 1'b0;
    wait_cke(1'b1, 20, n);
    check(cke, 1);
    e0 = edges;
    tick(2);
    check(edges, e0 + 1);
    burst_act = 1'b0;
  endtask
  task automatic t_burst;
    int n;
    int r0;
    burst_ref = 1'b1;
    r0 = refs;
    wait_ref(TREFI, n);
    for (int k = 1; k < 8; k++) begin
      tick();
      wait_ref(sdpc_pkg::TRFC_CYC + 8, n);
      check(n + 1 >= sdpc_pkg::TRFC_CYC && ref_pulse === 1'b1, 1);
    end
    burst_ref = 1'b0;
    tick(2);
    check(refs - r0, 8);
  endtask
  task automatic t_deep_pd;
    int n;
    deep_pd = 1'b1;
    wait_cke(1'b0, 40, n);
    check(cmd, sdpc_pkg::CMD_DPD);
    tick(10);
    check({mode, cke}, 7'h6);
    deep_pd = 1'b0;
    wait_cke(1'b1, 40, n);
    tick(3);
    check({mode, need_init}, 3'h1);
  endtask
  task automatic finish_test;
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence; reset state checked before release
  initial begin
    tick(10);
    check({cke, cmd, busy, need_init}, 7'h7C);
    rst = 1'b0;
    t_refresh();
    t_self_ref();
    t_power_down();
    t_suspend();
    t_burst();
    t_deep_pd();
    finish_test();
  end
endmodule // sdpc_ctrl_test
`default_nettype wire
